// ==== verilog/lcd_seq_pkg.sv ====
// Overview of operation
// - Nibble bit n drives common n, address per segment.
// - Settings and memory undefined until initialization.
// - Software reset command puts device in initial state.
// - Display control A4h: 80Hz, frame inversion, lowest power.
// - Display-on sequence starts driving from display memory.
// - RAM write sequence stores and shows new bytes.
// - Display-off halts; display-on restarts driving.
// - Bit 7 set: command follows; clear: data follows.
// - Software reset restores every setting default.
// - Address is operation P2 bit over address-set P4..P0.
// - Display-off stops outputs one frame later.
package lcd_seq_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int FR_HZ_0 = 80;
    localparam int FR_HZ_1 = 71;
    localparam int FR_HZ_2 = 64;
    localparam int FR_HZ_3 = 53;
    localparam int COM_N = 4;
    localparam int SEG_N = 36;
    localparam int QTR_W = 21;
    localparam int LINK_W = 9;
    localparam int FIFO_DEPTH = 4;
    localparam logic [7:0] SLAVE_BYTE = 8'h7C;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [5:0] ADDR_LAST = 6'h23;
    localparam logic [5:0] NIB_STEP = 6'h1;
    localparam logic [5:0] BYTE_STEP = 6'h2;
    localparam logic [1:0] OFF_LAST_QTR = 2'h3;
    localparam logic [1:0] COM_LAST = 2'h3;
    localparam logic [3:0] COM_ONE = 4'h1;
    localparam logic [1:0] GRP_ADDRESS_SET_CMD = 2'h0;
    localparam logic [1:0] GRP_DISPLAY_CONTROL_CMD = 2'h1;
    localparam logic [1:0] GRP_MODE = 2'h2;
    localparam logic [3:0] OP_IC_OPERATION_CMD = 4'hD;
    localparam logic [3:0] OP_BLINK = 4'hE;
    localparam logic [4:0] OP_ALLPIX = 5'h1F;

    typedef struct packed {
        logic cont; logic [1:0] grp; logic [4:0] arg;
    } cmd_t;
    typedef struct packed {
        logic cont; logic [3:0] op; logic msb; logic swrst; logic ext;
    } ic_operation_cmd_t;
    typedef struct packed {
        logic cont; logic [1:0] grp; logic [1:0] fr; logic wave;
        logic [1:0] sr;
    } display_control_cmd_t;
    typedef struct packed {
        logic cont; logic [1:0] grp; logic nc1; logic on; logic half;
        logic [1:0] nc0;
    } mode_set_cmd_t;
    typedef struct packed {
        logic cont; logic [3:0] op; logic [2:0] rate;
    } blink_control_cmd_t;
    typedef struct packed {
        logic cont; logic [4:0] op; logic on; logic off;
    } all_pixel_cmd_t;
    typedef struct packed {
        logic [3:0] hi; logic [3:0] lo;
    } dbyte_t;
    typedef struct packed {
        logic first; logic [7:0] data;
    } link_word_t;
    typedef struct packed {
        logic [1:0] fr; logic wave; logic [1:0] sr; logic on; logic half;
        logic [2:0] blink; logic ap_on; logic ap_off; logic ext; logic msb;
    } cfg_t;
    localparam cfg_t CFG_RST = '{fr: 2'h0, wave: 1'b0, sr: 2'h2,
        on: 1'b0, half: 1'b0, blink: 3'h0, ap_on: 1'b0, ap_off: 1'b0,
        ext: 1'b0, msb: 1'b0};

    typedef enum logic [1:0] {
        L_IDLE = 2'b00,
        L_RECV = 2'b01,
        L_ACK = 2'b10
    } link_st_t;
endpackage : lcd_seq_pkg

// ==== verilog/lcd_stream_if.sv ====
`timescale 1ns/10ps
interface lcd_stream_if #(parameter int WIDTH = 9);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : lcd_stream_if

// ==== verilog/lcd_byte_fifo.sv ====
`timescale 1ns/10ps
module lcd_byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Fill and drain sides
    lcd_stream_if.snk wr,
    lcd_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire logic push = wr.valid & wr.ready;
    wire logic pop = rd.valid & rd.ready;

    assign wr.ready = (cnt_q != FULL_CNT);
    assign rd.valid = (cnt_q != '0);
    assign rd.data = mem_q[rp_q];

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wp_q] <= wr.data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == LAST_IDX) ? '0 : AW'(wp_q + 1'b1);
            end
            if (pop) begin
                rp_q <= (rp_q == LAST_IDX) ? '0 : AW'(rp_q + 1'b1);
            end
            if (push && !pop) begin
                cnt_q <= (AW+1)'(cnt_q + 1'b1);
            end else if (pop && !push) begin
                cnt_q <= (AW+1)'(cnt_q - 1'b1);
            end
        end
    end
endmodule : lcd_byte_fifo

// ==== verilog/lcd_seq_top.sv ====
`timescale 1ns/10ps
module lcd_seq_top #(
    parameter int QTR_CYC_0 =
        lcd_seq_pkg::CLK_HZ / (lcd_seq_pkg::FR_HZ_0 * lcd_seq_pkg::COM_N),
    parameter int QTR_CYC_1 =
        lcd_seq_pkg::CLK_HZ / (lcd_seq_pkg::FR_HZ_1 * lcd_seq_pkg::COM_N),
    parameter int QTR_CYC_2 =
        lcd_seq_pkg::CLK_HZ / (lcd_seq_pkg::FR_HZ_2 * lcd_seq_pkg::COM_N),
    parameter int QTR_CYC_3 =
        lcd_seq_pkg::CLK_HZ / (lcd_seq_pkg::FR_HZ_3 * lcd_seq_pkg::COM_N)
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RST_N,
    // Two-wire serial link
    input wire logic I_SCL,
    output logic O_SCL,
    output logic O_SCL_OE,
    input wire logic I_SDA,
    output logic O_SDA,
    output logic O_SDA_OE,
    // Panel drive
    output logic [lcd_seq_pkg::COM_N-1:0] O_COM,
    output logic [lcd_seq_pkg::SEG_N-1:0] O_SEG,
    output logic O_POLARITY,
    output logic O_DRIVE_EN,
    // Settings seen by the analog side
    output logic [1:0] O_FRAME_RATE,
    output logic O_FRAME_INV,
    output logic [1:0] O_SEG_POWER,
    output logic O_BIAS_HALF,
    output logic [2:0] O_BLINK_RATE,
    output logic O_EXT_CLK_SEL
);
    import lcd_seq_pkg::*;

    // Link sampling: a level counts once the second and third stages agree.
    logic [2:0] scl_s_q;
    logic [2:0] sda_s_q;
    logic scl_f_q;
    logic sda_f_q;
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            scl_s_q <= 3'h7;
            sda_s_q <= 3'h7;
        end else begin
            scl_s_q <= {scl_s_q[1:0], I_SCL};
            sda_s_q <= {sda_s_q[1:0], I_SDA};
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            if (scl_s_q[1] == scl_s_q[2]) scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2]) sda_f_q <= sda_s_q[2];
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    wire logic scl_rise = scl_f_q & ~scl_p_q;
    wire logic scl_fall = ~scl_f_q & scl_p_q;
    wire logic start_ev = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
    wire logic stop_ev = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

    // Byte receiver. While a byte waits for FIFO room the clock is held low.
    link_st_t st_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic addr_ph_q;
    logic first_q;
    logic wr_valid_q;
    logic sda_oe_q;
    logic scl_oe_q;
    lcd_stream_if #(.WIDTH(LINK_W)) push_if ();
    lcd_stream_if #(.WIDTH(LINK_W)) pop_if ();
    wire logic addr_ok = (shift_q == SLAVE_BYTE);
    wire logic byte_end = scl_fall && (bit_cnt_q == BITS_PER_BYTE);

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            st_q <= L_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            addr_ph_q <= 1'b0;
            first_q <= 1'b0;
            wr_valid_q <= 1'b0;
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
        end else if (stop_ev) begin
            st_q <= L_IDLE;
            sda_oe_q <= 1'b0;
        end else if (start_ev) begin
            st_q <= L_RECV;
            bit_cnt_q <= 4'h0;
            addr_ph_q <= 1'b1;
            sda_oe_q <= 1'b0;
        end else begin
            case (st_q)
                L_RECV: begin
                    if (scl_rise && bit_cnt_q != BITS_PER_BYTE) begin
                        shift_q <= {shift_q[6:0], sda_f_q};
                        bit_cnt_q <= 4'(bit_cnt_q + 1'b1);
                    end else if (byte_end && addr_ph_q && !addr_ok) begin
                        st_q <= L_IDLE;
                    end else if (byte_end) begin
                        st_q <= L_ACK;
                        scl_oe_q <= 1'b1;
                        wr_valid_q <= !addr_ph_q;
                        if (addr_ph_q) first_q <= 1'b1;
                        addr_ph_q <= 1'b0;
                    end
                end
                L_ACK: begin
                    if (wr_valid_q) begin
                        if (push_if.ready) begin
                            wr_valid_q <= 1'b0;
                            first_q <= 1'b0;
                        end
                    end else if (!sda_oe_q) begin
                        sda_oe_q <= 1'b1;
                    end else if (scl_oe_q) begin
                        scl_oe_q <= 1'b0;
                    end else if (scl_fall) begin
                        sda_oe_q <= 1'b0;
                        st_q <= L_RECV;
                        bit_cnt_q <= 4'h0;
                    end
                end
                default: st_q <= L_IDLE;
            endcase
        end
    end

    assign push_if.valid = wr_valid_q;
    assign push_if.data = {first_q, shift_q};
    assign O_SDA = 1'b0;
    assign O_SCL = 1'b0;
    assign O_SDA_OE = sda_oe_q;
    assign O_SCL_OE = scl_oe_q;

    lcd_byte_fifo #(.WIDTH(LINK_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RST_N),
        .wr(push_if.snk),
        .rd(pop_if.src)
    );

    // Command interpreter. A data byte takes two cycles, one per nibble.
    cfg_t cfg_q;
    logic data_mode_q;
    logic nib_q;
    dbyte_t byte_q;
    logic [5:0] ptr_q;
    logic [3:0] mem_q [SEG_N];
    link_word_t w;
    assign w = pop_if.data;
    assign pop_if.ready = !nib_q;
    wire logic byte_fire = pop_if.valid & pop_if.ready;
    wire logic as_data = data_mode_q & !w.first;
    wire logic is_data = byte_fire & as_data;
    wire logic cmd_fire = byte_fire & !as_data;
    wire cmd_t c = cmd_t'(w.data);
    wire ic_operation_cmd_t ic = ic_operation_cmd_t'(w.data);
    wire display_control_cmd_t dc = display_control_cmd_t'(w.data);
    wire mode_set_cmd_t md = mode_set_cmd_t'(w.data);
    wire blink_control_cmd_t bk = blink_control_cmd_t'(w.data);
    wire all_pixel_cmd_t ap = all_pixel_cmd_t'(w.data);
    wire logic is_ic = cmd_fire && ic.op == OP_IC_OPERATION_CMD;
    wire logic is_sw = is_ic && ic.swrst;
    wire logic is_dc = cmd_fire && c.grp == GRP_DISPLAY_CONTROL_CMD;
    wire logic is_ad = cmd_fire && c.grp == GRP_ADDRESS_SET_CMD;
    wire logic is_md = cmd_fire && c.grp == GRP_MODE;
    wire logic is_bk = cmd_fire && bk.op == OP_BLINK;
    wire logic is_ap = cmd_fire && ap.op == OP_ALLPIX;
    wire logic [5:0] ad_tgt = {cfg_q.msb, c.arg};
    wire logic [5:0] ptr_lo = 6'(ptr_q + NIB_STEP);
    wire logic [5:0] ptr_plus2 = 6'(ptr_q + BYTE_STEP);
    wire logic [5:0] ptr_step = (ptr_plus2 > ADDR_LAST) ? 6'h00 : ptr_plus2;

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            cfg_q <= CFG_RST;
            data_mode_q <= 1'b0;
            nib_q <= 1'b0;
            byte_q <= 8'h00;
            ptr_q <= 6'h00;
        end else begin
            if (cmd_fire) data_mode_q <= !c.cont;
            nib_q <= is_data;
            if (is_data) byte_q <= dbyte_t'(w.data);
            if (is_sw) begin
                cfg_q <= CFG_RST;
                ptr_q <= 6'h00;
            end else begin
                if (is_ic) begin
                    cfg_q.msb <= ic.msb;
                    cfg_q.ext <= ic.ext;
                end
                if (is_dc) begin
                    cfg_q.fr <= dc.fr;
                    cfg_q.wave <= dc.wave;
                    cfg_q.sr <= dc.sr;
                end
                if (is_ad) begin
                    // Addresses past the last location fall back to zero.
                    ptr_q <= (ad_tgt > ADDR_LAST) ? 6'h00 : ad_tgt;
                end
                if (is_md) begin
                    cfg_q.on <= md.on;
                    cfg_q.half <= md.half;
                end
                if (is_bk) cfg_q.blink <= bk.rate;
                if (is_ap) begin
                    cfg_q.ap_on <= ap.on;
                    cfg_q.ap_off <= ap.off;
                end
                if (nib_q) ptr_q <= ptr_step;
            end
        end
    end

    // Frame scan: four common slots per frame, slot length set by rate.
    localparam logic [QTR_W-1:0] QTR_LAST [4] = '{
        QTR_W'(QTR_CYC_0 - 1), QTR_W'(QTR_CYC_1 - 1),
        QTR_W'(QTR_CYC_2 - 1), QTR_W'(QTR_CYC_3 - 1)};
    logic [QTR_W-1:0] qcnt_q;
    logic [1:0] com_idx_q;
    logic [1:0] off_cnt_q;
    logic drive_q;
    logic pol_q;
    logic [SEG_N-1:0] seg_raw;
    wire logic [QTR_W-1:0] qtr_last = QTR_LAST[cfg_q.fr];
    wire logic qtick = (qcnt_q >= qtr_last);
    wire logic frame_end = qtick && com_idx_q == COM_LAST;

    for (genvar g = 0; g < SEG_N; g++) begin : g_seg
        wire logic we_hi = is_data && ptr_q == 6'(g);
        wire logic we_lo = nib_q && ptr_lo == 6'(g);
        // Zeroed for a clean start; software still must not rely on it.
        always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
            if (!I_RST_N) begin
                mem_q[g] <= 4'h0;
            end else if (we_hi) begin
                mem_q[g] <= w.data[7:4];
            end else if (we_lo) begin
                mem_q[g] <= byte_q.lo;
            end
        end
        assign seg_raw[g] = mem_q[g][com_idx_q];
    end

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            qcnt_q <= '0;
            com_idx_q <= 2'h0;
            pol_q <= 1'b0;
        end else begin
            qcnt_q <= qtick ? '0 : QTR_W'(qcnt_q + 1'b1);
            if (qtick) com_idx_q <= 2'(com_idx_q + 1'b1);
            if (cfg_q.wave ? frame_end : qtick) pol_q <= !pol_q;
        end
    end

    // Display off counts four slot boundaries, one whole frame period.
    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            drive_q <= 1'b0;
            off_cnt_q <= 2'h0;
        end else if (is_sw) begin
            // Software reset returns straight to the blank initial state.
            drive_q <= 1'b0;
            off_cnt_q <= 2'h0;
        end else if (cfg_q.on) begin
            drive_q <= 1'b1;
            off_cnt_q <= 2'h0;
        end else if (drive_q && qtick) begin
            off_cnt_q <= 2'(off_cnt_q + 1'b1);
            if (off_cnt_q == OFF_LAST_QTR) drive_q <= 1'b0;
        end
    end

    // All-pixel off outranks all-pixel on; both apply only while driving.
    wire logic [SEG_N-1:0] seg_d = !drive_q ? '0 :
        cfg_q.ap_off ? '0 : cfg_q.ap_on ? '1 : seg_raw;
    wire logic [COM_N-1:0] com_d = drive_q ? 4'(COM_ONE << com_idx_q) : '0;

    always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_SEG <= '0;
            O_COM <= '0;
        end else begin
            O_SEG <= seg_d;
            O_COM <= com_d;
        end
    end

    assign O_POLARITY = pol_q;
    assign O_DRIVE_EN = drive_q;
    assign O_FRAME_RATE = cfg_q.fr;
    assign O_FRAME_INV = cfg_q.wave;
    assign O_SEG_POWER = cfg_q.sr;
    assign O_BIAS_HALF = cfg_q.half;
    assign O_BLINK_RATE = cfg_q.blink;
    assign O_EXT_CLK_SEL = cfg_q.ext;

    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RST_N);

    wire logic seg0_src = mem_q[0][com_idx_q];
    wire logic plain_scan = drive_q && !cfg_q.ap_on && !cfg_q.ap_off;

    chk_seg_map: assert property (
        plain_scan |=> O_SEG[0] == $past(seg0_src) && O_COM != '0)
        else $error("segment 0 does not follow its memory nibble");
    chk_swrst_defaults: assert property (
        is_sw |=> cfg_q == CFG_RST && ptr_q == 6'h00 && !drive_q ##3
        !drive_q || cfg_q.on)
        else $error("software reset left a setting changed");
    chk_display_control_cmd_decode: assert property (
        is_dc && w.data == 8'hA4 |=> cfg_q.fr == 2'h0 && cfg_q.wave
        && cfg_q.sr == 2'h0)
        else $error("display control A4h decoded wrongly");
    chk_cont_flag: assert property (
        cmd_fire && !c.cont && !is_sw |=> data_mode_q)
        else $error("cleared continuation bit did not enter data mode");
    chk_addr_compose: assert property (
        is_ad && !is_sw && ad_tgt <= ADDR_LAST |=> ptr_q == $past(ad_tgt))
        else $error("address pointer not built from both commands");
    chk_off_hold: assert property (
        drive_q && !cfg_q.on && !qtick && !is_sw |=> drive_q)
        else $error("drive stopped before the frame ran out");
    chk_off_stop: assert property (
        drive_q && !cfg_q.on && qtick && off_cnt_q == OFF_LAST_QTR
        |=> !drive_q ##1 O_COM == '0 && O_SEG == '0)
        else $error("drive did not stop one frame after display off");
    chk_on_restart: assert property (
        is_md && md.on && !is_sw ##1 !is_sw |-> ##1 O_DRIVE_EN)
        else $error("display on did not restart driving");
    chk_pair_step: assert property (
        is_data && !is_sw |=> !pop_if.ready ##1 ptr_q == $past(ptr_step))
        else $error("data byte did not advance the pointer by two");
    chk_nibble_hi: assert property (
        is_data && ptr_q == 6'h00 |=> mem_q[0] == $past(w.data[7:4]))
        else $error("upper nibble not stored at the pointer");
endmodule : lcd_seq_top

// ==== verification/lcd_host_model.sv ====
`timescale 1ns/10ps
module lcd_host_model (
    // Clock
    input wire logic i_clk,
    // Wire levels seen on the link
    input wire logic i_scl,
    input wire logic i_sda,
    // Host drive, high means released to the pull-up; o_stuck flags a clock held low
    output logic o_scl,
    output logic o_sda,
    output logic o_stuck
);
    localparam int HALF = 6;

    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_stuck = 1'b0;
    end

    task automatic half_bit();
        repeat (HALF) @(posedge i_clk);
    endtask : half_bit

    // The device may hold the clock low, so the high phase starts late.
    task automatic scl_high();
        int n;
        n = 0;
        o_scl <= 1'b1;
        @(posedge i_clk);
        while (i_scl !== 1'b1 && n < 4000) begin
            @(posedge i_clk);
            n++;
        end
        if (n >= 4000) o_stuck <= 1'b1;
        half_bit();
    endtask : scl_high

    // Data bits only move a cycle after the clock fell; start and stop change data under a high clock.
    task automatic scl_low();
        o_scl <= 1'b0;
        @(posedge i_clk);
    endtask : scl_low

    task automatic send_stop();
        o_sda <= 1'b0;
        half_bit();
        scl_high();
        o_sda <= 1'b1;
        half_bit();
    endtask : send_stop

    task automatic send_start();
        o_sda <= 1'b1;
        half_bit();
        scl_high();
        o_sda <= 1'b0;
        half_bit();
        scl_low();
    endtask : send_start

    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            o_sda <= b[i];
            half_bit();
            scl_high();
            scl_low();
        end
        o_sda <= 1'b1;
        half_bit();
        scl_high();
        ack = (i_sda === 1'b0);
        scl_low();
    endtask : send_byte
endmodule : lcd_host_model

// ==== verification/lcd_segment_display_sequencing_test.sv ====
`timescale 1ns/10ps
module lcd_segment_display_sequencing_test;
    import lcd_seq_pkg::*;
    localparam int QTR = 40;
    logic I_REF_CLK;
    logic I_RST_N;
    logic host_scl, host_sda, stuck, scl_oe, sda_oe, drive_en, frame_inv;
    logic ext_sel, pol, bias_half;
    logic [1:0] frame_rate, seg_power;
    logic [2:0] blink_rate;
    logic [COM_N-1:0] com;
    logic [SEG_N-1:0] segment_line;
    logic [3:0] nib [SEG_N];
    int mismatches;
    int checked;
    // Both lines carry pull-ups, so a released line reads high.
    wire logic scl_w = host_scl & ~scl_oe;
    wire logic sda_w = host_sda & ~sda_oe;

    lcd_seq_top #(
        .QTR_CYC_0(QTR), .QTR_CYC_1(QTR), .QTR_CYC_2(QTR), .QTR_CYC_3(QTR)
    ) u_dut (
        .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N),
        .I_SCL(scl_w), .O_SCL(), .O_SCL_OE(scl_oe),
        .I_SDA(sda_w), .O_SDA(), .O_SDA_OE(sda_oe),
        .O_COM(com), .O_SEG(segment_line), .O_POLARITY(pol), .O_DRIVE_EN(drive_en),
        .O_FRAME_RATE(frame_rate), .O_FRAME_INV(frame_inv),
        .O_SEG_POWER(seg_power), .O_BIAS_HALF(bias_half),
        .O_BLINK_RATE(blink_rate), .O_EXT_CLK_SEL(ext_sel)
    );

    lcd_host_model u_host (
        .i_clk(I_REF_CLK), .i_scl(scl_w), .i_sda(sda_w),
        .o_scl(host_scl), .o_sda(host_sda), .o_stuck(stuck)
    );

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic xfer(input logic [7:0] q[$]);
        logic ack;
        u_host.send_start();
        u_host.send_byte(SLAVE_BYTE, ack);
        check(ack, 1'b1);
        foreach (q[i]) begin
            u_host.send_byte(q[i], ack);
            check(ack, 1'b1);
        end
        u_host.send_stop();
        repeat (4) @(posedge I_REF_CLK);
    endtask : xfer

    task automatic wait_drive(input logic lvl);
        int n;
        n = 0;
        while (drive_en !== lvl && n < 4 * QTR + 8) begin
            @(negedge I_REF_CLK);
            n++;
        end
        check(drive_en, lvl);
        if (n >= 4 * QTR + 8) end_sim();
    endtask : wait_drive

    // Walks one frame and compares every slot against the shadow memory.
    task automatic scan();
        logic [SEG_N-1:0] exp;
        logic p0;
        int n;
        p0 = 1'b0;
        for (int c = 0; c < COM_N; c++) begin
            n = 0;
            while (com !== COM_ONE << c && n < 4 * QTR) begin
                @(negedge I_REF_CLK);
                n++;
            end
            for (int s = 0; s < SEG_N; s++) exp[s] = nib[s][c];
            check(com, COM_ONE << c);
            if (n >= 4 * QTR) end_sim();
            check(segment_line, exp);
            // Frame inversion keeps one polarity for all slots of a frame.
            if (c == 0) p0 = pol;
            check(pol, p0);
        end
    endtask : scan

    initial begin
        I_REF_CLK = 1'b0;
        forever #2 I_REF_CLK = ~I_REF_CLK;
    end

    initial begin
        repeat (100000) @(posedge I_REF_CLK);
        mismatches++;
        $display("mismatch at %0t: got %0h expected %0h", $time, 0, 1);
        end_sim();
    end

    initial begin
        logic ack;
        logic [7:0] q[$];
        mismatches = 0;
        checked = 0;
        I_RST_N = 1'b0;
        repeat (2) @(posedge I_REF_CLK);
        I_RST_N <= 1'b1;
        repeat (5) @(posedge I_REF_CLK);
        check(frame_rate, 2'h0);
        check(seg_power, 2'h2);
        check(drive_en, 1'b0);
        check(bias_half, 1'b0);
        $display("test reset_defaults done");

        repeat (25000) @(posedge I_REF_CLK);
        u_host.send_stop();
        for (int i = 0; i < SEG_N; i++) nib[i] = 4'(i * 7 + 3);
        q = '{8'hEA, 8'hA4, 8'hE8, 8'h00};
        for (int k = 0; k < 18; k++) q.push_back({nib[2*k], nib[2*k+1]});
        xfer(q);
        check(frame_rate, 2'h0);
        check(frame_inv, 1'b1);
        check(seg_power, 2'h0);
        xfer('{8'hA4, 8'hF0, 8'hFC, 8'hC8});
        check(blink_rate, 3'h0);
        check(bias_half, 1'b0);
        wait_drive(1'b1);
        scan();
        $display("test init_and_display_on done");

        nib[34] = 4'hA;
        nib[35] = 4'h5;
        nib[0] = 4'hB;
        nib[1] = 4'hB;
        xfer('{8'hEC, 8'h02, 8'hA5, 8'hBB});
        check(frame_rate, 2'h0);
        scan();
        $display("test ram_write done");

        u_host.send_start();
        u_host.send_byte(SLAVE_BYTE, ack);
        u_host.send_byte(8'h40, ack);
        check(drive_en, 1'b1);
        wait_drive(1'b0);
        @(negedge I_REF_CLK);
        check(com, 4'h0);
        check(segment_line, 36'h0);
        u_host.send_stop();
        xfer('{8'hA4, 8'hF0, 8'hFC, 8'hC8});
        wait_drive(1'b1);
        scan();
        $display("test display_off_on done");

        xfer('{8'hBB, 8'hE9});
        check(frame_rate, 2'h3);
        check(seg_power, 2'h3);
        check(ext_sel, 1'b1);
        xfer('{8'hEA});
        check(frame_rate, 2'h0);
        check(frame_inv, 1'b0);
        check(seg_power, 2'h2);
        check(ext_sel, 1'b0);
        $display("test software_reset done");

        u_host.send_start();
        u_host.send_byte(8'h7A, ack);
        check(ack, 1'b0);
        u_host.send_stop();
        check(stuck, 1'b0);
        $display("test foreign_address done");
        end_sim();
    end
endmodule : lcd_segment_display_sequencing_test
